// ===== design/cfgp_stream.sv
// Summary of operation
// - Serial data appears on the one output bit with reconfig high and selects active.
// - Each rising configuration clock edge that finds data on the pins advances to the next bit or byte.
// - In slave modes an outside clock is used, or this block drives the clock.
// - Byte data is driven only with busy low, reconfig high, selects active.
// - Active revision comes from the select pins or the internal select bits.
// - Compressed images are expanded on the fly into the output stream.
// - Storage holds 33,554,432 bits and the stream pointer spans all of it.
// - Chain enable rises when this device's stream ends, letting the next one follow.
// - During in-system programming chain enable is high and other outputs are released.
// - A read-protected revision refuses read and verify over the programming port.
// - Read protection does not block program or erase.
// - Read protection clears only when that revision is erased.
// - A write-protected revision refuses both program and erase.
// - The reconfigure command reloads the selected revision and, unless in-system programming is active, pulses reconfig low once.
`timescale 1ns/1ps
module cfgp_stream #(
   parameter int unsigned MEM_BYTES   = cfgp_pkg::CAP_BYTES,
   parameter int unsigned RECONF_CYC  = cfgp_pkg::RECONF_LOW_CYC,
   parameter int unsigned CONFIG_CLOCK_HALF   = cfgp_pkg::CONFIG_CLOCK_HALF_CYC,
   localparam int unsigned AW         = $clog2(MEM_BYTES),
   localparam int unsigned RAW        = AW - cfgp_pkg::REV_W
) (
   input  wire logic                        clk_i,
   input  wire logic                        srst_i,
   input  wire logic                        config_clock_i,
   input  wire logic                        ce_n_i,
   input  wire logic                        oe_i,
   input  wire logic                        busy_i,
   input  wire logic [cfgp_pkg::REV_W-1:0]  revision_select_pins_i,
   input  wire logic [cfgp_pkg::REV_W-1:0]  rev_sel_int_i,
   input  wire logic                        use_int_sel_i,
   input  wire logic                        byte_parallel_mode_i,
   input  wire logic                        drive_clock_i,
   input  wire logic                        compress_en_i,
   input  wire logic                        isp_active_i,
   input  wire logic                        reconfig_cmd_i,
   input  wire logic                        cmd_valid_i,
   input  wire cfgp_pkg::cfgp_op_t          cmd_op_i,
   input  wire logic [cfgp_pkg::REV_W-1:0]  cmd_rev_i,
   input  wire logic [RAW-1:0]              cmd_addr_i,
   input  wire logic [7:0]                  cmd_wdata_i,
   output logic                             serial_config_out_o,
   output logic [7:0]                       parallel_config_out_o,
   output logic                             config_oe_n_o,
   output logic                             config_clock_o,
   output logic                             config_clock_oe_n_o,
   output logic                             chain_enable_out_o,
   output logic                             fpga_reconfig_pulse_n_o,
   output logic [cfgp_pkg::REV_W-1:0]       active_rev_o,
   output logic                             cmd_busy_o,
   output logic                             cmd_done_o,
   output logic                             cmd_ok_o,
   output logic [7:0]                       cmd_rdata_o
);
   localparam int unsigned SW = 4 + cfgp_pkg::REV_W;
   localparam int unsigned RC = $clog2(RECONF_CYC + 1);
   localparam int unsigned CC = $clog2(CONFIG_CLOCK_HALF + 1);

   // Pin synchronisers
   logic [SW-1:0] pin_raw, s1_q, s2_q;
   assign pin_raw = {config_clock_i, ce_n_i, oe_i, busy_i, revision_select_pins_i};
   for (genvar g = 0; g < SW; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
         s1_q[g] <= pin_raw[g];
         s2_q[g] <= s1_q[g];
      end
   end
   logic                       config_clock_s, ce_act, oe_act, busy_s, config_clock_prev_q;
   logic [cfgp_pkg::REV_W-1:0] pins_s;
   assign {config_clock_s, ce_act, oe_act, busy_s, pins_s} = {s2_q[SW-1], ~s2_q[SW-2], s2_q[SW-3:0]};

   logic [7:0] mem [MEM_BYTES];

   // Clock generation for slave modes
   logic [CC-1:0] div_q;
   logic          int_rise;
   assign int_rise = (div_q == CC'(CONFIG_CLOCK_HALF - 1)) && !config_clock_o;
   always_ff @(posedge clk_i) begin
      if (srst_i || !drive_clock_i) begin
         div_q          <= '0;
         config_clock_o <= 1'b0;
      end else if (div_q == CC'(CONFIG_CLOCK_HALF - 1)) begin
         div_q          <= '0;
         config_clock_o <= !config_clock_o;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      config_clock_prev_q         <= srst_i ? 1'b0 : config_clock_s;
      config_clock_oe_n_o <= srst_i ? cfgp_pkg::OE_N_OFF : !(drive_clock_i && !isp_active_i);
   end
   logic config_clock_rise;
   // Edge from our own divider when driving, else sampled outside clock; never gated
   assign config_clock_rise = drive_clock_i ? int_rise : (config_clock_s && !config_clock_prev_q);

   // Reconfiguration pulse and revision reload
   logic [RC-1:0] rc_cnt_q;
   logic          boot_q, reload;
   assign reload = boot_q || (reconfig_cmd_i && rc_cnt_q == '0);
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         boot_q                  <= 1'b1;
         rc_cnt_q                <= '0;
         fpga_reconfig_pulse_n_o <= cfgp_pkg::RECONF_IDLE;
         active_rev_o            <= '0;
      end else begin
         boot_q <= 1'b0;
         if (reload) begin
            active_rev_o <= use_int_sel_i ? rev_sel_int_i : pins_s;
         end
         if (reconfig_cmd_i && rc_cnt_q == '0 && !isp_active_i) begin
            rc_cnt_q                <= RC'(RECONF_CYC);
            fpga_reconfig_pulse_n_o <= 1'b0;
         end else if (rc_cnt_q != '0) begin
            rc_cnt_q                <= rc_cnt_q - 1'b1;
            fpga_reconfig_pulse_n_o <= (rc_cnt_q == RC'(1));
         end
      end
   end

   // Stream fetch; start waits a cycle for the newly latched revision
   logic [AW-1:0] ptr_q, end_ptr;
   logic [7:0]    fb_q;
   logic          fb_valid_q, start_q, more_q, in_ready, ub_valid, ub_ready, ub_idle, stream_done;
   logic [7:0]    ub_byte;
   assign end_ptr     = {active_rev_o, {RAW{1'b1}}};
   assign stream_done = !start_q && !more_q && !fb_valid_q && ub_idle;
   always_ff @(posedge clk_i) begin
      if (srst_i || reload) begin
         ptr_q      <= '0;
         fb_valid_q <= 1'b0;
         fb_q       <= 8'h0_000;
         start_q    <= 1'b1;
         more_q     <= 1'b0;
      end else if (start_q && !isp_active_i) begin
         // Memory may be mid-rewrite while programming, so fetching waits
         ptr_q   <= {active_rev_o, {RAW{1'b0}}};
         start_q <= 1'b0;
         more_q  <= 1'b1;
      end else if (more_q && !isp_active_i && (!fb_valid_q || in_ready)) begin
         fb_q       <= mem[ptr_q];
         fb_valid_q <= 1'b1;
         more_q     <= (ptr_q != end_ptr);
         ptr_q      <= ptr_q + 1'b1;
      end else if (fb_valid_q && in_ready) begin
         fb_valid_q <= 1'b0;
      end
   end

   cfgp_unpack u_unpack (
      .clk_i       (clk_i),
      .srst_i      (srst_i),
      .restart_i   (reload),
      .bypass_i    (!compress_en_i),
      .in_byte_i   (fb_q),
      .in_valid_i  (fb_valid_q),
      .in_ready_o  (in_ready),
      .out_byte_o  (ub_byte),
      .out_valid_o (ub_valid),
      .out_ready_i (ub_ready),
      .idle_o      (ub_idle)
   );

   // Presentation to the FPGA
   logic       drv_ok, advance, need_byte;
   logic [2:0] bit_q;
   logic [7:0] cur_q;
   logic       have_q;
   assign drv_ok    = ce_act && oe_act && fpga_reconfig_pulse_n_o && !isp_active_i
                      && (!byte_parallel_mode_i || !busy_s);
   // Only an edge that found the byte on the pins consumes it
   assign advance   = drv_ok && config_clock_rise && !config_oe_n_o;
   assign need_byte = !have_q || (advance && (byte_parallel_mode_i || bit_q == 3'h7));
   assign ub_ready  = need_byte;
   always_ff @(posedge clk_i) begin
      if (srst_i || reload) begin
         bit_q  <= '0;
         cur_q  <= 8'h0_000;
         have_q <= 1'b0;
      end else begin
         if (advance && !byte_parallel_mode_i) begin
            bit_q <= bit_q + 1'b1;
         end
         if (need_byte) begin
            have_q <= ub_valid;
            cur_q  <= ub_byte;
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         serial_config_out_o   <= 1'b0;
         parallel_config_out_o <= 8'h0_000;
         config_oe_n_o         <= cfgp_pkg::OE_N_OFF;
         chain_enable_out_o    <= 1'b0;
      end else begin
         serial_config_out_o   <= cur_q[3'h7 - bit_q];
         parallel_config_out_o <= cur_q;
         config_oe_n_o         <= !(drv_ok && have_q);
         chain_enable_out_o    <= isp_active_i || (stream_done && !have_q && !ub_valid);
      end
   end

   // Programming port with per-revision protection
   typedef enum logic [1:0] {CFGP_IDLE, CFGP_READ, CFGP_ERASE} cfgp_cst_t;
   cfgp_cst_t                    cst_q;
   logic [cfgp_pkg::NUM_REV-1:0] rp_q, wp_q;
   logic [RAW-1:0]               ea_q;
   logic [cfgp_pkg::REV_W-1:0]   crev_q;
   logic                         cmd_take;
   assign cmd_take = cmd_valid_i && cst_q == CFGP_IDLE;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cst_q       <= CFGP_IDLE;
         rp_q        <= '0;
         wp_q        <= '0;
         ea_q        <= '0;
         crev_q      <= '0;
         cmd_busy_o  <= 1'b0;
         cmd_done_o  <= 1'b0;
         cmd_ok_o    <= 1'b0;
         cmd_rdata_o <= 8'h0_000;
      end else begin
         cmd_done_o <= 1'b0;
         case (cst_q)
            CFGP_IDLE: begin
               if (cmd_take) begin
                  crev_q <= cmd_rev_i;
                  ea_q   <= cmd_addr_i;
                  case (cmd_op_i)
                     cfgp_pkg::CFGP_OP_READ: begin
                        cst_q      <= CFGP_READ;
                        cmd_busy_o <= 1'b1;
                     end
                     cfgp_pkg::CFGP_OP_PROG: begin
                        if (!wp_q[cmd_rev_i]) begin
                           mem[{cmd_rev_i, cmd_addr_i}] <= cmd_wdata_i;
                        end
                        cmd_ok_o   <= !wp_q[cmd_rev_i];
                        cmd_done_o <= 1'b1;
                     end
                     cfgp_pkg::CFGP_OP_ERASE: begin
                        if (wp_q[cmd_rev_i]) begin
                           cmd_ok_o   <= 1'b0;
                           cmd_done_o <= 1'b1;
                        end else begin
                           ea_q       <= '0;
                           cst_q      <= CFGP_ERASE;
                           cmd_busy_o <= 1'b1;
                        end
                     end
                     cfgp_pkg::CFGP_OP_SET_RP: begin
                        rp_q[cmd_rev_i] <= 1'b1;
                        cmd_ok_o        <= 1'b1;
                        cmd_done_o      <= 1'b1;
                     end
                     cfgp_pkg::CFGP_OP_SET_WP: begin
                        wp_q[cmd_rev_i] <= 1'b1;
                        cmd_ok_o        <= 1'b1;
                        cmd_done_o      <= 1'b1;
                     end
                     cfgp_pkg::CFGP_OP_UNLOCK: begin
                        wp_q[cmd_rev_i] <= 1'b0;
                        cmd_ok_o        <= 1'b1;
                        cmd_done_o      <= 1'b1;
                     end
                     default: begin
                        cmd_ok_o   <= 1'b0;
                        cmd_done_o <= 1'b1;
                     end
                  endcase
               end
            end
            CFGP_READ: begin
               // Protected data never leaves on the read path
               cmd_rdata_o <= rp_q[crev_q] ? 8'h0_000 : mem[{crev_q, ea_q}];
               cmd_ok_o    <= !rp_q[crev_q];
               cmd_done_o  <= 1'b1;
               cmd_busy_o  <= 1'b0;
               cst_q       <= CFGP_IDLE;
            end
            CFGP_ERASE: begin
               mem[{crev_q, ea_q}] <= cfgp_pkg::ERASED_VAL;
               ea_q                <= ea_q + 1'b1;
               if (ea_q == {RAW{1'b1}}) begin
                  rp_q[crev_q] <= 1'b0;
                  cmd_ok_o     <= 1'b1;
                  cmd_done_o   <= 1'b1;
                  cmd_busy_o   <= 1'b0;
                  cst_q        <= CFGP_IDLE;
               end
            end
            default: cst_q <= CFGP_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   sequence s_prog_take;
      cmd_take && cmd_op_i == cfgp_pkg::CFGP_OP_PROG;
   endsequence
   sequence s_reconf_take;
      reconfig_cmd_i && rc_cnt_q == '0 && !isp_active_i;
   endsequence

   isp_chain_high_a: assert property (isp_active_i |=> chain_enable_out_o && config_oe_n_o)
      else $error("ISP active but chain enable low or data driven");
   sel_off_hiz_a: assert property (!(ce_act && oe_act) |=> config_oe_n_o)
      else $error("Data driven with a select inactive");
   sel_off_hold_a: assert property (!(ce_act && oe_act) && have_q |=> $stable(bit_q) && $stable(cur_q))
      else $error("Stream advanced with a select inactive");
   byte_busy_hiz_a: assert property (byte_parallel_mode_i && busy_s |=> config_oe_n_o)
      else $error("Byte data driven while busy");
   ser_bit_step_a: assert property (advance && !byte_parallel_mode_i |=> bit_q == $past(bit_q) + 3'h1)
      else $error("Serial bit did not advance on clock edge");
   reconf_pulse_a: assert property (s_reconf_take |=> !fpga_reconfig_pulse_n_o [*3] ##1 fpga_reconfig_pulse_n_o)
      else $error("Reconfig pulse width wrong");
   wp_prog_block_a: assert property ((s_prog_take and wp_q[cmd_rev_i]) |=> cmd_done_o && !cmd_ok_o)
      else $error("Program accepted on write-protected revision");
   rp_prog_allow_a: assert property ((s_prog_take and !wp_q[cmd_rev_i]) |=> cmd_done_o && cmd_ok_o)
      else $error("Program refused though not write-protected");
   rp_read_block_a: assert property (cst_q == CFGP_READ && rp_q[crev_q] |=> !cmd_ok_o && cmd_rdata_o == 8'h0_000)
      else $error("Protected revision data returned");
   rp_clear_a: assert property ($fell(rp_q[1]) |-> $past(cst_q) == CFGP_ERASE && $past(crev_q) == 2'h1)
      else $error("Read protect cleared by other than its erase");
endmodule : cfgp_stream

// ===== design/cfgp_pkg.sv
package cfgp_pkg;
   // Storage geometry
   localparam int unsigned CAP_BITS   = 33554432;
   localparam int unsigned CAP_BYTES  = CAP_BITS / 8;
   localparam int unsigned NUM_REV    = 4;
   localparam int unsigned REV_W      = 2;
   localparam logic [7:0]  ERASED_VAL = 8'h0_0FF;

   // Compressed stream header byte layout
   localparam int unsigned HDR_RUN_BIT = 7;
   localparam int unsigned HDR_CNT_W   = 7;

   // Timing
   localparam int unsigned CLK_PERIOD_NS    = 100;
   localparam int unsigned RECONF_LOW_NS    = 300;
   localparam int unsigned RECONF_LOW_CYC   = (RECONF_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CONFIG_CLOCK_HALF_NS     = 400;
   localparam int unsigned CONFIG_CLOCK_HALF_CYC    = CONFIG_CLOCK_HALF_NS / CLK_PERIOD_NS;
   localparam int unsigned SYNC_STAGES      = 2;

   // Reset values
   localparam logic        RECONF_IDLE = 1'b1;
   localparam logic        OE_N_OFF    = 1'b1;

   typedef enum logic [2:0] {
      CFGP_OP_READ,
      CFGP_OP_PROG,
      CFGP_OP_ERASE,
      CFGP_OP_SET_RP,
      CFGP_OP_SET_WP,
      CFGP_OP_UNLOCK
   } cfgp_op_t;
endpackage : cfgp_pkg

// ===== design/cfgp_unpack.sv
`timescale 1ns/1ps
module cfgp_unpack (
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   input  wire logic       restart_i,
   input  wire logic       bypass_i,
   input  wire logic [7:0] in_byte_i,
   input  wire logic       in_valid_i,
   output logic            in_ready_o,
   output logic [7:0]      out_byte_o,
   output logic            out_valid_o,
   input  wire logic       out_ready_i,
   output logic            idle_o
);
   typedef enum logic [1:0] {CFGP_HDR, CFGP_LIT, CFGP_RUN_VAL, CFGP_RUN_OUT} cfgp_ust_t;

   cfgp_ust_t                          st_q;
   logic [cfgp_pkg::HDR_CNT_W-1:0]     cnt_q;
   logic                               slot_free;

   assign slot_free = !out_valid_o || out_ready_i;
   assign idle_o    = (st_q == CFGP_HDR) && !out_valid_o;

   always_comb begin
      in_ready_o = 1'b0;
      if (restart_i) begin
         in_ready_o = 1'b0;
      end else if (bypass_i) begin
         in_ready_o = slot_free;
      end else begin
         case (st_q)
            CFGP_HDR:     in_ready_o = 1'b1;
            CFGP_LIT:     in_ready_o = slot_free;
            CFGP_RUN_VAL: in_ready_o = slot_free;
            default:      in_ready_o = 1'b0;
         endcase
      end
   end

   // Header: bit 7 set is a run of cnt+1 copies of the next byte, clear is cnt+1 literals
   always_ff @(posedge clk_i) begin
      if (srst_i || restart_i) begin
         st_q        <= CFGP_HDR;
         cnt_q       <= '0;
         out_valid_o <= 1'b0;
         out_byte_o  <= 8'h0_000;
      end else begin
         if (out_valid_o && out_ready_i) begin
            out_valid_o <= 1'b0;
         end
         if (bypass_i) begin
            if (in_valid_i && in_ready_o) begin
               out_byte_o  <= in_byte_i;
               out_valid_o <= 1'b1;
            end
         end else begin
            case (st_q)
               CFGP_HDR: begin
                  if (in_valid_i) begin
                     cnt_q <= in_byte_i[cfgp_pkg::HDR_CNT_W-1:0];
                     st_q  <= in_byte_i[cfgp_pkg::HDR_RUN_BIT] ? CFGP_RUN_VAL : CFGP_LIT;
                  end
               end
               CFGP_LIT, CFGP_RUN_VAL: begin
                  if (in_valid_i && in_ready_o) begin
                     out_byte_o  <= in_byte_i;
                     out_valid_o <= 1'b1;
                     if (cnt_q == '0) begin
                        st_q <= CFGP_HDR;
                     end else begin
                        cnt_q <= cnt_q - 1'b1;
                        if (st_q == CFGP_RUN_VAL) begin
                           st_q <= CFGP_RUN_OUT;
                        end
                     end
                  end
               end
               CFGP_RUN_OUT: begin
                  if (slot_free) begin
                     out_valid_o <= 1'b1;
                     if (cnt_q == '0) begin
                        st_q <= CFGP_HDR;
                     end else begin
                        cnt_q <= cnt_q - 1'b1;
                     end
                  end
               end
               default: st_q <= CFGP_HDR;
            endcase
         end
      end
   end
endmodule : cfgp_unpack

// ===== verif/cfgp_fpga_model.sv
`timescale 1ns/1ps
module cfgp_fpga_model (
   input  wire logic       data_oe_n_i,
   input  wire logic       serial_i,
   input  wire logic [7:0] byte_i,
   output logic            config_clock_o
);
   logic [7:0] cap_q [16];
   logic [7:0] bits_q;
   initial config_clock_o = 1'b0;
   // Clock stands low between frames; odd offset keeps it apart from clk_i
   task automatic run(input int n);
      #37;
      for (int i = 0; i < n; i++) begin
         #400;
         config_clock_o = 1'b1;
         // Released bus shows the inverse, never a stale match
         cap_q[i] = data_oe_n_i ? ~byte_i : byte_i;
         bits_q = {bits_q[6:0], serial_i};
         #400;
         config_clock_o = 1'b0;
      end
   endtask : run
endmodule : cfgp_fpga_model

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic               clk_i = 1'b0;
   logic               srst_i = 1'b1;
   logic               ce_n_i = 1'b1, oe_i = 1'b0, busy_i = 1'b0, use_int_sel_i = 1'b0;
   logic               byte_parallel_mode_i = 1'b1, compress_en_i = 1'b0, isp_active_i = 1'b0;
   logic               reconfig_cmd_i = 1'b0, cmd_valid_i = 1'b0, config_clock;
   logic [1:0]         revision_select_pins_i = 2'h0, rev_sel_int_i = 2'h0, cmd_rev_i = 2'h0, active_rev_o;
   logic [3:0]         cmd_addr_i = 4'h0;
   logic [7:0]         cmd_wdata_i = 8'h00, parallel_config_out_o, cmd_rdata_o;
   logic               serial_config_out_o, config_oe_n_o, chain_enable_out_o;
   logic               fpga_reconfig_pulse_n_o, cmd_done_o, cmd_ok_o;
   logic               drive_clock_i = 1'b0, cfg_clk_drv, cfg_clk_oe_n, cmd_busy_o;
   cfgp_pkg::cfgp_op_t cmd_op_i = cfgp_pkg::CFGP_OP_READ;
   int                 n_mismatch = 0;
   int                 total_checks = 0;
   logic [7:0]         img [16];
   logic [7:0]         cimg [5] = '{8'h83, 8'hA5, 8'h01, 8'h11, 8'h22};
   logic [7:0]         dimg [6] = '{8'hA5, 8'hA5, 8'hA5, 8'hA5, 8'h11, 8'h22};
   always #50 clk_i = ~clk_i;
   cfgp_stream #(.MEM_BYTES(64)) cfgp_stream_i (
      .clk_i(clk_i), .srst_i(srst_i), .config_clock_i(config_clock), .ce_n_i(ce_n_i), .oe_i(oe_i),
      .busy_i(busy_i), .revision_select_pins_i(revision_select_pins_i), .rev_sel_int_i(rev_sel_int_i),
      .use_int_sel_i(use_int_sel_i), .byte_parallel_mode_i(byte_parallel_mode_i), .drive_clock_i(drive_clock_i),
      .compress_en_i(compress_en_i), .isp_active_i(isp_active_i), .reconfig_cmd_i(reconfig_cmd_i),
      .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_rev_i(cmd_rev_i), .cmd_addr_i(cmd_addr_i),
      .cmd_wdata_i(cmd_wdata_i), .serial_config_out_o(serial_config_out_o),
      .parallel_config_out_o(parallel_config_out_o), .config_oe_n_o(config_oe_n_o), .config_clock_o(cfg_clk_drv),
      .config_clock_oe_n_o(cfg_clk_oe_n), .chain_enable_out_o(chain_enable_out_o),
      .fpga_reconfig_pulse_n_o(fpga_reconfig_pulse_n_o), .active_rev_o(active_rev_o), .cmd_busy_o(cmd_busy_o),
      .cmd_done_o(cmd_done_o), .cmd_ok_o(cmd_ok_o), .cmd_rdata_o(cmd_rdata_o));
   cfgp_fpga_model cfgp_fpga_model_i (
      .data_oe_n_i(config_oe_n_o), .serial_i(serial_config_out_o), .byte_i(parallel_config_out_o),
      .config_clock_o(config_clock));
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic report_and_stop();
      $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic cmd(input cfgp_pkg::cfgp_op_t op, input logic [1:0] rev, input logic [3:0] addr,
                      input logic [7:0] wd, input logic ok, input logic [7:0] rd);
      logic busy_exp;
      busy_exp = (op == cfgp_pkg::CFGP_OP_READ) || (op == cfgp_pkg::CFGP_OP_ERASE && ok);
      @(posedge clk_i);
      cmd_valid_i <= 1'b1;
      cmd_op_i <= op;
      cmd_rev_i <= rev;
      cmd_addr_i <= addr;
      cmd_wdata_i <= wd;
      @(posedge clk_i);
      cmd_valid_i <= 1'b0;
      #1 check("busy", 8'(cmd_busy_o), 8'(busy_exp));
      for (int i = 0; i < 40 && cmd_done_o !== 1'b1; i++) @(posedge clk_i) #1;
      check("done", 8'(cmd_done_o), 8'h01);
      check("ok", 8'(cmd_ok_o), 8'(ok));
      if (op == cfgp_pkg::CFGP_OP_READ) check("rdata", cmd_rdata_o, rd);
   endtask : cmd
   task automatic reload(input logic [1:0] rev);
      int low;
      low = 0;
      // Let the pin synchronisers settle before the revision is latched
      repeat (4) @(posedge clk_i);
      reconfig_cmd_i <= 1'b1;
      @(posedge clk_i);
      reconfig_cmd_i <= 1'b0;
      repeat (10) begin
         #1 low += int'(fpga_reconfig_pulse_n_o === 1'b0);
         @(posedge clk_i);
      end
      check("reconf_low", 8'(low), 8'h03);
      check("active_rev", 8'(active_rev_o), 8'(rev));
      repeat (10) @(posedge clk_i);
   endtask : reload
   initial begin
      #500_000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (6) @(posedge clk_i);
      srst_i <= 1'b0;
      isp_active_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      #1 check("isp_chain", 8'(chain_enable_out_o), 8'h01);
      check("isp_oe_n", 8'(config_oe_n_o), 8'h01);
      check("isp_clk_oe_n", 8'(cfg_clk_oe_n), 8'h01);
      cmd(cfgp_pkg::CFGP_OP_PROG, 2'h0, 4'h0, 8'h3C, 1'b1, 8'h00);
      for (int i = 0; i < 16; i++) begin
         img[i] = 8'h30 + 8'(i * 7);
         cmd(cfgp_pkg::CFGP_OP_PROG, 2'h2, 4'(i), img[i], 1'b1, 8'h00);
      end
      foreach (cimg[i]) cmd(cfgp_pkg::CFGP_OP_PROG, 2'h3, 4'(i), cimg[i], 1'b1, 8'h00);
      cmd(cfgp_pkg::CFGP_OP_READ, 2'h2, 4'h5, 8'h00, 1'b1, img[5]);
      cmd(cfgp_pkg::CFGP_OP_PROG, 2'h1, 4'h0, 8'h5A, 1'b1, 8'h00);
      cmd(cfgp_pkg::CFGP_OP_SET_RP, 2'h1, 4'h0, 8'h00, 1'b1, 8'h00);
      cmd(cfgp_pkg::CFGP_OP_READ, 2'h1, 4'h0, 8'h00, 1'b0, 8'h00);
      cmd(cfgp_pkg::CFGP_OP_PROG, 2'h1, 4'h0, 8'h66, 1'b1, 8'h00);
      cmd(cfgp_pkg::CFGP_OP_SET_WP, 2'h1, 4'h0, 8'h00, 1'b1, 8'h00);
      cmd(cfgp_pkg::CFGP_OP_PROG, 2'h1, 4'h0, 8'h77, 1'b0, 8'h00);
      cmd(cfgp_pkg::CFGP_OP_ERASE, 2'h1, 4'h0, 8'h00, 1'b0, 8'h00);
      cmd(cfgp_pkg::CFGP_OP_UNLOCK, 2'h1, 4'h0, 8'h00, 1'b1, 8'h00);
      cmd(cfgp_pkg::CFGP_OP_ERASE, 2'h1, 4'h0, 8'h00, 1'b1, 8'h00);
      cmd(cfgp_pkg::CFGP_OP_READ, 2'h1, 4'h0, 8'h00, 1'b1, 8'hFF);
      isp_active_i <= 1'b0;
      ce_n_i <= 1'b0;
      oe_i <= 1'b1;
      revision_select_pins_i <= 2'h2;
      reload(2'h2);
      cfgp_fpga_model_i.run(4);
      for (int i = 0; i < 4; i++) check("byte", cfgp_fpga_model_i.cap_q[i], img[i]);
      @(posedge clk_i);
      ce_n_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      #1 check("desel_oe_n", 8'(config_oe_n_o), 8'h01);
      cfgp_fpga_model_i.run(3);
      @(posedge clk_i);
      ce_n_i <= 1'b0;
      busy_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      #1 check("busy_oe_n", 8'(config_oe_n_o), 8'h01);
      cfgp_fpga_model_i.run(2);
      @(posedge clk_i);
      busy_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      cfgp_fpga_model_i.run(12);
      for (int i = 0; i < 12; i++) check("byte", cfgp_fpga_model_i.cap_q[i], img[i + 4]);
      repeat (10) @(posedge clk_i);
      #1 check("chain_end", 8'(chain_enable_out_o), 8'h01);
      @(posedge clk_i);
      byte_parallel_mode_i <= 1'b0;
      reload(2'h2);
      cfgp_fpga_model_i.run(8);
      check("serial", cfgp_fpga_model_i.bits_q, img[0]);
      @(posedge clk_i);
      byte_parallel_mode_i <= 1'b1;
      compress_en_i <= 1'b1;
      use_int_sel_i <= 1'b1;
      rev_sel_int_i <= 2'h3;
      reload(2'h3);
      cfgp_fpga_model_i.run(6);
      foreach (dimg[i]) check("unpacked", cfgp_fpga_model_i.cap_q[i], dimg[i]);
      @(posedge clk_i);
      compress_en_i <= 1'b0;
      rev_sel_int_i <= 2'h2;
      reload(2'h2);
      #1 check("first_byte", parallel_config_out_o, img[0]);
      @(posedge clk_i);
      drive_clock_i <= 1'b1;
      // Each falling edge shows the byte left by the rising edge before it
      for (int i = 1; i < 4; i++) begin
         @(negedge cfg_clk_drv) #1;
         check("drv_byte", parallel_config_out_o, img[i]);
      end
      check("drv_clk_oe_n", 8'(cfg_clk_oe_n), 8'h00);
      report_and_stop();
   end
endmodule : tb_top
